// >>> mhbe_clkdiv.sv
`default_nettype none
// Divides the core clock into the bus clock and flags each phase boundary.
module mhbe_clkdiv (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	output logic bus_clk_q,
	output logic phase_tick
);
	import mhbe_pkg::*;
	logic [3:0] cnt_q;
	wire last_count = (cnt_q == MHBE_CLK_HALF - 4'h1);
	assign phase_tick = clk_en && last_count;
	// Divider runs whenever clk_en is high, so the peripheral sees a steady clock.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 4'h0;
			bus_clk_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= last_count ? 4'h0 : cnt_q + 4'h1;
			if (last_count) begin
				bus_clk_q <= ~bus_clk_q;
			end
		end
	end
endmodule
`default_nettype wire

// >>> mhbe_host_bus.sv
// Contract
// - Read strobe is low only while a read asks for data, else high.
// - Write data settles before the write strobe falls and outlasts it.
// - A low wait-ready input stretches the cycle while it stays low.
// - The bus clock pin carries the clock that times the bus cycles.
// - The aux pins form a high byte that commands set, clear or read.
// - A wait-for-level command stalls until aux pin one shows that level.
// - An interrupt read waits for aux pin one, then reads and returns data.
// - While waiting for a level, aux pin one is an input and is not driven.
// - Chip select is low through every read or write cycle, else high.
// - Each cycle opens with a latch pulse while the low address is out.
// - One 8-bit bus carries the low address and then data, both ways.
// - The upper address byte is driven on its own output byte.
`default_nettype none
module mhbe_host_bus (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire mhbe_pkg::mhbe_cmd_t cmd_code,
	input wire logic [15:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	input wire logic [7:0] addr_data_mux_in,
	output logic [7:0] addr_data_mux_out,
	output logic addr_data_mux_oe,
	output logic [7:0] addr_high,
	output logic chip_select_n,
	output logic addr_latch,
	output logic read_n,
	output logic write_n,
	input wire logic wait_ready_in,
	output logic bus_clock_out,
	input wire logic aux_pin_zero_in,
	output logic aux_pin_zero_out,
	output logic aux_pin_zero_oe,
	input wire logic aux_pin_one_wait_in,
	output logic aux_pin_one_wait_out,
	output logic aux_pin_one_wait_oe
);
	import mhbe_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_LATCH, S_ADDR_HOLD, S_STROBE, S_RECOVER, S_WAIT_LVL
	} mhbe_state_t;

	mhbe_state_t state_q;
	mhbe_cmd_t cmd_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q, aux_out_q, aux_dir_q;
	logic [3:0] ph_q;
	logic want_level_q;
	logic bus_clk_q, tick;

	// Shared bus clock also paces every cycle phase.
	mhbe_clkdiv u_clkdiv (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.bus_clk_q(bus_clk_q),
		.phase_tick(tick)
	);

	// Command decode and phase conditions.
	wire is_read = (cmd_q == MHBE_CMD_READ) || (cmd_q == MHBE_CMD_IRQ_READ);
	wire take = clk_en && cmd_ready && cmd_valid;
	wire level_seen = (aux_pin_one_wait_in == want_level_q);
	wire strobe_min = (ph_q >= MHBE_STROBE_PHASES - 4'h1);
	wire strobe_done = tick && strobe_min && wait_ready_in;
	wire [7:0] aux_in = {6'h00, aux_pin_one_wait_in, aux_pin_zero_in};
	wire [7:0] aux_set = cmd_data & cmd_addr[7:0];
	wire [7:0] aux_clr = ~cmd_data & cmd_addr[7:0];
	wire starts_cycle = (cmd_code == MHBE_CMD_READ) ||
		(cmd_code == MHBE_CMD_WRITE);
	wire starts_wait = (cmd_code == MHBE_CMD_WAIT_HIGH) ||
		(cmd_code == MHBE_CMD_WAIT_LOW) || (cmd_code == MHBE_CMD_IRQ_READ);

	// Sequencer: command accept, level wait, latch, strobe and recovery.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= S_IDLE;
			cmd_q <= MHBE_CMD_READ;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			ph_q <= 4'h0;
			want_level_q <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else if (clk_en) begin
			rsp_valid <= 1'b0;
			case (state_q)
			S_IDLE: begin
				cmd_ready <= 1'b1;
				if (take) begin
					cmd_q <= cmd_code;
					addr_q <= cmd_addr;
					wdata_q <= cmd_data;
					// Interrupt reads wait for the request line to go high.
					want_level_q <= (cmd_code == MHBE_CMD_WAIT_HIGH) ||
						(cmd_code == MHBE_CMD_IRQ_READ);
					if (starts_cycle) begin
						cmd_ready <= 1'b0;
						state_q <= S_LATCH;
					end else if (starts_wait) begin
						cmd_ready <= 1'b0;
						state_q <= S_WAIT_LVL;
					end else if (cmd_code == MHBE_CMD_GET_AUX) begin
						rsp_valid <= 1'b1;
						rsp_data <= aux_in;
					end
				end
			end
			S_WAIT_LVL: begin
				// Stall until the pin matches; interrupt reads then run a read.
				if (level_seen) begin
					if (cmd_q == MHBE_CMD_IRQ_READ) begin
						state_q <= S_LATCH;
					end else begin
						state_q <= S_IDLE;
					end
				end
			end
			S_LATCH: if (tick) state_q <= S_ADDR_HOLD;
			S_ADDR_HOLD: if (tick) begin
				ph_q <= 4'h0;
				state_q <= S_STROBE;
			end
			S_STROBE: begin
				if (tick && !strobe_min) ph_q <= ph_q + 4'h1;
				if (strobe_done) begin
					if (is_read) begin
						rsp_valid <= 1'b1;
						rsp_data <= addr_data_mux_in;
					end
					state_q <= S_RECOVER;
				end
			end
			S_RECOVER: if (tick) state_q <= S_IDLE;
			default: state_q <= S_IDLE;
			endcase
		end
	end

	// Auxiliary byte: a set/clear command writes masked bits and direction.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			aux_out_q <= MHBE_AUX_OUT_RST;
			aux_dir_q <= MHBE_AUX_DIR_RST;
		end else if (clk_en && take && cmd_code == MHBE_CMD_SET_AUX) begin
			aux_out_q <= (aux_out_q | aux_set) & ~aux_clr;
			aux_dir_q <= cmd_addr[15:8];
		end
	end

	// Pin drivers, all registered so the pins never glitch.
	wire in_cycle = (state_q == S_LATCH) || (state_q == S_ADDR_HOLD) ||
		(state_q == S_STROBE);
	wire nxt_latch = (state_q == S_LATCH);
	wire nxt_strobe = (state_q == S_STROBE) && !strobe_done;
	// The address leaves the bus one cycle before the strobe falls, so
	// write data is already settled when the write strobe goes low.
	wire nxt_addr_ph = (state_q == S_LATCH) ||
		(state_q == S_ADDR_HOLD && !tick);
	wire write_cyc = in_cycle && !is_read;
	wire waiting = (state_q == S_WAIT_LVL);
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			addr_data_mux_out <= 8'h00;
			addr_data_mux_oe <= 1'b0;
			addr_high <= 8'h00;
			chip_select_n <= 1'b1;
			addr_latch <= 1'b0;
			read_n <= 1'b1;
			write_n <= 1'b1;
			bus_clock_out <= 1'b0;
			aux_pin_zero_out <= 1'b0;
			aux_pin_zero_oe <= 1'b0;
			aux_pin_one_wait_out <= 1'b0;
			aux_pin_one_wait_oe <= 1'b0;
		end else if (clk_en) begin
			bus_clock_out <= bus_clk_q;
			chip_select_n <= !in_cycle;
			addr_latch <= nxt_latch;
			addr_high <= addr_q[15:8];
			// Data held through recovery so it outlasts the write strobe.
			addr_data_mux_out <= nxt_addr_ph ? addr_q[7:0] : wdata_q;
			addr_data_mux_oe <= nxt_addr_ph || write_cyc ||
				(state_q == S_RECOVER && !is_read);
			read_n <= !(nxt_strobe && is_read);
			write_n <= !(nxt_strobe && !is_read);
			aux_pin_zero_out <= aux_out_q[MHBE_AUX0_BIT];
			aux_pin_zero_oe <= aux_dir_q[MHBE_AUX0_BIT];
			aux_pin_one_wait_out <= aux_out_q[MHBE_AUX1_BIT];
			aux_pin_one_wait_oe <= aux_dir_q[MHBE_AUX1_BIT] && !waiting &&
				!(take && starts_wait);
		end
	end

	a_read_strobe_idle: assert property (
		@(posedge core_clk) disable iff (reset)
		(!in_cycle && state_q != S_RECOVER) |=> read_n)
		else $error("read strobe low outside a read");
	a_write_data_setup: assert property (
		@(posedge core_clk) disable iff (reset)
		$fell(write_n) |-> addr_data_mux_oe && $stable(addr_data_mux_out))
		else $error("write data not set up before strobe");
	a_write_data_hold: assert property (
		@(posedge core_clk) disable iff (reset)
		$rose(write_n) |-> addr_data_mux_oe)
		else $error("write data not held after strobe");
	a_wait_extends: assert property (
		@(posedge core_clk) disable iff (reset)
		(state_q == S_STROBE && !wait_ready_in && clk_en) |=>
		state_q == S_STROBE)
		else $error("cycle ended while wait ready low");
	a_clock_output: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en |=> bus_clock_out == $past(bus_clk_q))
		else $error("bus clock pin not following bus clock");
	a_level_stall: assert property (
		@(posedge core_clk) disable iff (reset)
		(waiting && !level_seen && clk_en) |=> waiting && !cmd_ready)
		else $error("stall left before level seen");
	a_irq_then_read: assert property (
		@(posedge core_clk) disable iff (reset)
		(waiting && level_seen && clk_en && cmd_q == MHBE_CMD_IRQ_READ) |=>
		state_q == S_LATCH)
		else $error("interrupt read not started");
	a_aux_one_input: assert property (
		@(posedge core_clk) disable iff (reset)
		waiting |=> !aux_pin_one_wait_oe)
		else $error("aux pin one driven while waiting");
	a_select_strobe: assert property (
		@(posedge core_clk) disable iff (reset)
		(!read_n || !write_n || addr_latch) |-> !chip_select_n)
		else $error("strobe without chip select");
	a_latch_addr: assert property (
		@(posedge core_clk) disable iff (reset)
		addr_latch |-> addr_data_mux_oe && addr_data_mux_out == addr_q[7:0])
		else $error("latch pulse without low address");
endmodule
`default_nettype wire

// >>> mhbe_host_bus_test.sv
`default_nettype none
// Drives commands into the bus emulation block and judges its answers.
module mhbe_host_bus_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mhbe_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, slow = 1'b0;
	logic a0x = 1'b0, a1x = 1'b0, clk_en = 1'b1;
	mhbe_cmd_t cmd_code = MHBE_CMD_READ;
	logic [15:0] cmd_addr = 16'h0000;
	logic [7:0] cmd_data = 8'h00;
	wire [7:0] rsp_data, addr_data_mux_in, addr_data_mux_out, addr_high;
	wire cmd_ready, rsp_valid, addr_data_mux_oe, chip_select_n, addr_latch;
	wire read_n, write_n, wait_ready_in, bus_clock_out, a0o, a0e, a1o, a1e;
	int err_count = 0, cmp_count = 0, fast_n = 0;
	// Aux wires follow the block when it drives, else the outside level.
	wire a0i = a0e ? a0o : a0x;
	wire a1i = a1e ? a1o : a1x;
	always #2 core_clk = ~core_clk;
	mhbe_host_bus i_dut (.core_clk, .reset, .clk_en, .cmd_valid,
		.cmd_code, .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data,
		.addr_data_mux_in, .addr_data_mux_out, .addr_data_mux_oe, .addr_high,
		.chip_select_n, .addr_latch, .read_n, .write_n, .wait_ready_in,
		.bus_clock_out, .aux_pin_zero_in(a0i), .aux_pin_zero_out(a0o),
		.aux_pin_zero_oe(a0e), .aux_pin_one_wait_in(a1i),
		.aux_pin_one_wait_out(a1o), .aux_pin_one_wait_oe(a1e));
	mhbe_periph i_per (.core_clk, .slow, .addr_data_mux_out,
		.addr_data_mux_oe, .addr_high, .chip_select_n, .addr_latch, .read_n,
		.write_n, .addr_data_mux_in, .wait_ready_in);
	task automatic test_done();
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// A hung handshake ends the run at once with a counted mismatch.
	task automatic ready_wait(output int n);
		n = 0;
		while (cmd_ready !== 1'b1) begin
			n++;
			if (n > 300) begin
				chk(8'h00, 8'hFF);
				test_done();
			end
			@(negedge core_clk);
		end
	endtask
	task automatic send(input mhbe_cmd_t c, input logic [15:0] a,
		input logic [7:0] d);
		int n;
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_addr = a;
		cmd_data = d;
		ready_wait(n);
		@(negedge core_clk);
		cmd_valid = 1'b0;
	endtask
	task automatic get_rsp(output logic [7:0] d, output int n);
		n = 0;
		while (rsp_valid !== 1'b1) begin
			n++;
			if (n > 300) begin
				chk(8'h00, 8'hFF);
				test_done();
			end
			@(negedge core_clk);
		end
		d = rsp_data;
	endtask
	// Same low byte under two high bytes proves the upper address is used.
	task automatic t_rw();
		logic [7:0] d;
		int n;
		send(MHBE_CMD_WRITE, 16'hA55A, 8'hC3);
		send(MHBE_CMD_WRITE, 16'h015A, 8'h3C);
		send(MHBE_CMD_READ, 16'hA55A, 8'h00);
		get_rsp(d, n);
		chk(d, 8'hC3);
		send(MHBE_CMD_READ, 16'h015A, 8'h00);
		get_rsp(d, fast_n);
		chk(d, 8'h3C);
	endtask
	task automatic t_slow();
		logic [7:0] d;
		logic b;
		int n, t;
		slow = 1'b1;
		send(MHBE_CMD_WRITE, 16'h00FF, 8'h81);
		send(MHBE_CMD_READ, 16'h00FF, 8'h00);
		t = 0;
		repeat (12) begin
			b = bus_clock_out;
			@(negedge core_clk);
			t += (bus_clock_out !== b);
		end
		chk(8'(t), 8'(12 / MHBE_CLK_HALF));
		get_rsp(d, n);
		slow = 1'b0;
		chk(d, 8'h81);
		chk(8'(n + 12 >= fast_n + 6), 8'h01);
	endtask
	task automatic t_aux();
		logic [7:0] d;
		int n;
		send(MHBE_CMD_SET_AUX, 16'h0101, 8'h01);
		// The pin registers follow the aux byte one cycle later.
		@(negedge core_clk);
		chk({6'h00, a0e, a0o}, 8'h03);
		a1x = 1'b1;
		send(MHBE_CMD_GET_AUX, 16'h0000, 8'h00);
		get_rsp(d, n);
		chk(d, 8'h03);
		send(MHBE_CMD_SET_AUX, 16'h0101, 8'h00);
		send(MHBE_CMD_GET_AUX, 16'h0000, 8'h00);
		get_rsp(d, n);
		chk(d, 8'h02);
	endtask
	// Aux one is driven away from the awaited level just before each wait.
	task automatic t_wait();
		int n;
		for (int i = 0; i < 2; i++) begin
			send(MHBE_CMD_SET_AUX, 16'h0202, {6'h00, i == 0, 1'b0});
			a1x = (i == 0);
			send(i ? MHBE_CMD_WAIT_HIGH : MHBE_CMD_WAIT_LOW, 16'h0000, 8'h00);
			chk({7'h00, a1e}, 8'h00);
			n = 0;
			repeat (20) begin
				@(negedge core_clk);
				n += (cmd_ready !== 1'b0);
			end
			chk(8'(n), 8'h00);
			a1x = (i != 0);
			ready_wait(n);
			chk(8'(n < 16), 8'h01);
		end
	endtask
	task automatic t_irq();
		logic [7:0] d;
		int n;
		a1x = 1'b0;
		send(MHBE_CMD_IRQ_READ, 16'hA55A, 8'h00);
		n = 0;
		repeat (20) begin
			@(negedge core_clk);
			n += (read_n !== 1'b1);
		end
		chk(8'(n), 8'h00);
		a1x = 1'b1;
		get_rsp(d, n);
		chk(d, 8'hC3);
	endtask
	// With the clock enable low the bus clock pin must not move.
	task automatic t_freeze();
		logic b;
		int n;
		clk_en = 1'b0;
		b = bus_clock_out;
		n = 0;
		repeat (10) begin
			@(negedge core_clk);
			n += (bus_clock_out !== b);
		end
		clk_en = 1'b1;
		chk(8'(n), 8'h00);
	endtask
	initial begin
		repeat (6) @(negedge core_clk);
		chk({5'h00, chip_select_n, read_n, write_n}, 8'h07);
		reset = 1'b0;
		t_rw();
		t_slow();
		t_aux();
		t_wait();
		t_irq();
		t_freeze();
		test_done();
	end
endmodule
`default_nettype wire

// >>> mhbe_periph.sv
`default_nettype none
// Peripheral on the multiplexed bus: latches the address, keeps written
// bytes and answers reads, stretching each strobe when slow is set.
module mhbe_periph (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic [7:0] addr_data_mux_out,
	input wire logic addr_data_mux_oe,
	input wire logic [7:0] addr_high,
	input wire logic chip_select_n,
	input wire logic addr_latch,
	input wire logic read_n,
	input wire logic write_n,
	output logic [7:0] addr_data_mux_in,
	output logic wait_ready_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	logic [15:0] addr_q;
	logic [7:0] last_q = 8'h00;
	logic [3:0] stall_q = 4'h0;
	logic idle_q = 1'b1;
	logic wr_q = 1'b1;
	wire rd_on = !chip_select_n && !read_n;
	wire idle = read_n && write_n;
	// A released bus shows the inverse of its last level, so a read that
	// samples nobody's data cannot pass by luck.
	assign addr_data_mux_in = addr_data_mux_oe ? addr_data_mux_out :
		rd_on ? mem[addr_q] : ~last_q;
	assign wait_ready_in = !(slow && stall_q != 4'h0);
	// Data is taken just after the write strobe rises, where it must hold.
	always @(posedge core_clk) begin
		last_q <= addr_data_mux_in;
		idle_q <= idle;
		wr_q <= write_n;
		if (addr_latch)
			addr_q <= {addr_high, addr_data_mux_in};
		if (write_n && !wr_q)
			mem[addr_q] <= addr_data_mux_in;
		if (idle_q && !idle)
			stall_q <= 4'hA;
		else if (stall_q != 4'h0)
			stall_q <= stall_q - 4'h1;
	end
endmodule
`default_nettype wire

// >>> mhbe_pkg.sv
`default_nettype none
package mhbe_pkg;
	// Command codes presented on the command port by the serial engine.
	typedef enum logic [2:0] {
		MHBE_CMD_READ,
		MHBE_CMD_WRITE,
		MHBE_CMD_SET_AUX,
		MHBE_CMD_GET_AUX,
		MHBE_CMD_WAIT_HIGH,
		MHBE_CMD_WAIT_LOW,
		MHBE_CMD_IRQ_READ
	} mhbe_cmd_t;
	// Bus clock divider: bus clock toggles every this many core cycles.
	localparam logic [3:0] MHBE_CLK_HALF = 4'h2;
	// Minimum strobe low time in bus clock phases before wait is honoured.
	localparam logic [3:0] MHBE_STROBE_PHASES = 4'h2;
	// Values after reset.
	localparam logic [7:0] MHBE_AUX_OUT_RST = 8'h00;
	localparam logic [7:0] MHBE_AUX_DIR_RST = 8'h00;
	// Bit positions of the auxiliary pins inside the high data byte.
	localparam int MHBE_AUX0_BIT = 0;
	localparam int MHBE_AUX1_BIT = 1;
endpackage
`default_nettype wire
